/* File: logic/pcsia_pkg.sv */
package pcsia_pkg;

    // widths of the program counter and its sources, stack depth, and data address and location widths
    localparam int PC_W = 13;
    localparam int LOW_W = 8;
    localparam int LATCH_W = 5;
    localparam int TARGET_W = 11;
    localparam int STACK_DEPTH = 8;
    localparam int DATA_ADDR_W = 9;
    localparam int LOC_W = 7;

    // field positions inside pc_high_latch
    localparam int LATCH_PAGE_LSB = 3;

    // status register bit positions
    localparam int STATUS_IND_BANK_BIT = 7;
    localparam int STATUS_BANK_HI_BIT = 6;
    localparam int STATUS_BANK_LO_BIT = 5;

    // register byte offsets on the bus
    localparam logic [7:0] OFS_PC_LOW = 8'h00;
    localparam logic [7:0] OFS_PC_LATCH = 8'h04;
    localparam logic [7:0] OFS_FILE_PTR = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;

    // reset values
    localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
    localparam logic [LATCH_W-1:0] LATCH_RESET = 5'h00;
    localparam logic [LOW_W-1:0] FILE_PTR_RESET = 8'h00;
    localparam logic [2:0] BANK_RESET = 3'h0;

    // interrupt vector and the location of the indirect data port
    localparam logic [PC_W-1:0] VECTOR_ADDR = 13'h0004;
    localparam logic [LOC_W-1:0] INDIRECT_LOC = 7'h00;
    localparam logic [LOW_W-1:0] NULL_READ = 8'h00;

    // program flow commands from the core
    typedef enum logic [2:0] {
        PCSIA_OP_NONE,
        PCSIA_OP_STEP,
        PCSIA_OP_GOTO,
        PCSIA_OP_CALL,
        PCSIA_OP_RETURN,
        PCSIA_OP_RETLIT,
        PCSIA_OP_RETINT,
        PCSIA_OP_VECTOR
    } pcsia_op_e;

    typedef struct packed {
        pcsia_op_e op;
        logic [TARGET_W-1:0] target;
    } pcsia_cmd_s;

    // data memory access requested by the core
    typedef struct packed {
        logic valid;
        logic we;
        logic [LOC_W-1:0] loc;
        logic [LOW_W-1:0] wdata;
    } pcsia_dreq_s;

endpackage : pcsia_pkg

/* File: logic/pcsia_stack.sv */
`timescale 1ns/100ps
module pcsia_stack #(
    parameter int DEPTH = 8,
    parameter int WIDTH = 13
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // stack actions
    input wire logic push,
    input wire logic pop,
    input wire logic [WIDTH-1:0] push_data,
    output logic [WIDTH-1:0] top_data
);

    localparam int PW = $clog2(DEPTH);

    // wrap by natural overflow needs a power of two
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
    begin : g_depth_check
        $error("pcsia_stack depth must be a power of two");
    end

    logic [PW-1:0] ptr_q;
    logic [PW-1:0] ptr_d;
    logic [PW-1:0] top_idx;
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] mem_d [DEPTH];

    // pointer wraps silently, no overflow or underflow flag exists
    always_comb
    begin
        ptr_d = ptr_q;
        if (push)
        begin
            ptr_d = ptr_q + 1'b1;
        end
        else if (pop)
        begin
            ptr_d = ptr_q - 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ptr_q <= '0;
        end
        else
        begin
            ptr_q <= ptr_d;
        end
    end

    // one slot per entry; a ninth push lands on the oldest slot
    for (genvar i = 0; i < DEPTH; i++)
    begin : g_entry
        always_comb
        begin
            mem_d[i] = mem_q[i];
            if (push && ptr_q == PW'(i))
            begin
                mem_d[i] = push_data;
            end
        end

        always_ff @(posedge clk)
        begin
            if (rst)
            begin
                mem_q[i] <= '0;
            end
            else
            begin
                mem_q[i] <= mem_d[i];
            end
        end
    end

    // most recent push sits just below the pointer
    assign top_idx = ptr_q - 1'b1;
    assign top_data = mem_q[top_idx];

endmodule : pcsia_stack

/* File: logic/pcsia_indaddr.sv */
`timescale 1ns/100ps
module pcsia_indaddr (
    // addressing state
    input wire logic [pcsia_pkg::LOW_W-1:0] file_ptr,
    input wire logic ind_bank,
    input wire logic bank_hi,
    input wire logic bank_lo,
    // location from the opcode
    input wire logic [pcsia_pkg::LOC_W-1:0] loc,
    // resolved address
    output logic [pcsia_pkg::DATA_ADDR_W-1:0] eff_addr,
    output logic indirect,
    output logic null_access
);

    // indirect port is mirrored in every bank, so only the low seven bits count
    always_comb
    begin
        indirect = (loc == pcsia_pkg::INDIRECT_LOC);
        null_access = indirect && (file_ptr[pcsia_pkg::LOC_W-1:0] == pcsia_pkg::INDIRECT_LOC);
        if (indirect)
        begin
            eff_addr = {ind_bank, file_ptr};
        end
        else
        begin
            eff_addr = {bank_hi, bank_lo, loc};
        end
    end

endmodule : pcsia_indaddr

/* File: logic/pcsia_core.sv */
`timescale 1ns/100ps
// Functional notes
// - program counter is thirteen bits wide.
// - low byte of the counter is program_counter_low, readable and writable.
// - counter bits 12..8 are not directly accessible; they come from pc_high_latch.
// - writing program_counter_low loads upper counter bits from pc_high_latch 4..0.
// - call and goto take the top two counter bits from pc_high_latch 4..3.
// - every reset clears the whole program counter.
// - hardware return stack holds eight thirteen-bit entries.
// - stack is outside program and data space; pointer is invisible to software.
// - call and interrupt vectoring push the counter onto the stack.
// - return, return_with_literal and return_from_interrupt pop into the counter.
// - push and pop never change pc_high_latch.
// - stack wraps; ninth push overwrites the first, tenth the second.
// - no overflow or underflow status is given.
// - indirect_data_port has no storage; access goes to file_select_pointer target.
// - reading indirect_data_port through itself returns 00h.
// - writing indirect_data_port through itself stores nothing.
// - indirect address is indirect_bank_bit above the eight-bit file_select_pointer.
module pcsia_core #(
    parameter int STACK_DEPTH = pcsia_pkg::STACK_DEPTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // wishbone register slave
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [7:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_dat_w,
    output logic [31:0] wb_dat_r,
    output logic wb_ack,
    // program flow from the core
    input wire pcsia_pkg::pcsia_cmd_s cmd,
    output logic [pcsia_pkg::PC_W-1:0] pc,
    // data access from the core
    input wire pcsia_pkg::pcsia_dreq_s dreq,
    output logic [pcsia_pkg::LOW_W-1:0] dreq_rdata,
    // data memory
    output logic [pcsia_pkg::DATA_ADDR_W-1:0] mem_addr,
    output logic mem_we,
    output logic [pcsia_pkg::LOW_W-1:0] mem_wdata,
    input wire logic [pcsia_pkg::LOW_W-1:0] mem_rdata
);

    // a deeper stack needs a power of two for its wrap
    if (STACK_DEPTH < 2)
    begin : g_depth_check
        $error("pcsia_core stack depth too small");
    end

    logic [pcsia_pkg::PC_W-1:0] pc_q;
    logic [pcsia_pkg::PC_W-1:0] pc_d;
    logic [pcsia_pkg::LATCH_W-1:0] latch_q;
    logic [pcsia_pkg::LATCH_W-1:0] latch_d;
    logic [pcsia_pkg::LOW_W-1:0] file_ptr_q;
    logic [pcsia_pkg::LOW_W-1:0] file_ptr_d;
    logic [2:0] bank_q;
    logic [2:0] bank_d;
    logic ack_q;
    logic ack_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [pcsia_pkg::LOW_W-1:0] drd_q;
    logic [pcsia_pkg::LOW_W-1:0] drd_d;
    logic bus_req;
    logic bus_wr;
    logic wr_pc_low;
    logic wr_latch;
    logic wr_file_ptr;
    logic wr_status;
    logic push;
    logic pop;
    logic [pcsia_pkg::PC_W-1:0] push_data;
    logic [pcsia_pkg::PC_W-1:0] top_data;
    logic [pcsia_pkg::PC_W-1:0] pc_next_seq;
    logic [pcsia_pkg::LOW_W-1:0] status_rd;
    logic [pcsia_pkg::DATA_ADDR_W-1:0] eff_addr;
    logic ind_access;
    logic null_access;

    // a new request is taken once; ack drops the cycle after it rose
    assign bus_req = wb_cyc && wb_stb && !ack_q;
    assign bus_wr = bus_req && wb_we && wb_sel[0];

    // address decode of the write strobes
    always_comb
    begin
        wr_pc_low = 1'b0;
        wr_latch = 1'b0;
        wr_file_ptr = 1'b0;
        wr_status = 1'b0;
        if (!bus_wr)
        begin
            wr_pc_low = 1'b0;
        end
        else if (wb_adr == pcsia_pkg::OFS_PC_LOW)
        begin
            wr_pc_low = 1'b1;
        end
        else if (wb_adr == pcsia_pkg::OFS_PC_LATCH)
        begin
            wr_latch = 1'b1;
        end
        else if (wb_adr == pcsia_pkg::OFS_FILE_PTR)
        begin
            wr_file_ptr = 1'b1;
        end
        else if (wb_adr == pcsia_pkg::OFS_STATUS)
        begin
            wr_status = 1'b1;
        end
    end

    // status view of the bank bits, other bits read zero
    always_comb
    begin
        status_rd = '0;
        status_rd[pcsia_pkg::STATUS_IND_BANK_BIT] = bank_q[2];
        status_rd[pcsia_pkg::STATUS_BANK_HI_BIT] = bank_q[1];
        status_rd[pcsia_pkg::STATUS_BANK_LO_BIT] = bank_q[0];
    end

    // bus answer; unmapped offsets ack with zero data and drop writes
    always_comb
    begin
        ack_d = bus_req;
        rdata_d = rdata_q;
        if (!bus_req)
        begin
            rdata_d = rdata_q;
        end
        else if (wb_adr == pcsia_pkg::OFS_PC_LOW)
        begin
            rdata_d = {24'h00_0000, pc_q[pcsia_pkg::LOW_W-1:0]};
        end
        else if (wb_adr == pcsia_pkg::OFS_PC_LATCH)
        begin
            rdata_d = {27'h000_0000, latch_q};
        end
        else if (wb_adr == pcsia_pkg::OFS_FILE_PTR)
        begin
            rdata_d = {24'h00_0000, file_ptr_q};
        end
        else if (wb_adr == pcsia_pkg::OFS_STATUS)
        begin
            rdata_d = {24'h00_0000, status_rd};
        end
        else
        begin
            rdata_d = 32'h0000_0000;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end
        else
        begin
            ack_q <= ack_d;
            rdata_q <= rdata_d;
        end
    end

    assign wb_ack = ack_q;
    assign wb_dat_r = rdata_q;

    // software-visible addressing and latch state
    always_comb
    begin
        latch_d = latch_q;
        file_ptr_d = file_ptr_q;
        bank_d = bank_q;
        if (wr_latch)
        begin
            latch_d = wb_dat_w[pcsia_pkg::LATCH_W-1:0];
        end
        if (wr_file_ptr)
        begin
            file_ptr_d = wb_dat_w[pcsia_pkg::LOW_W-1:0];
        end
        if (wr_status)
        begin
            // only the three bank bits are stored; reserved bits are dropped and read back as zero
            bank_d = {wb_dat_w[pcsia_pkg::STATUS_IND_BANK_BIT],
                      wb_dat_w[pcsia_pkg::STATUS_BANK_HI_BIT],
                      wb_dat_w[pcsia_pkg::STATUS_BANK_LO_BIT]};
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            latch_q <= pcsia_pkg::LATCH_RESET;
            file_ptr_q <= pcsia_pkg::FILE_PTR_RESET;
            bank_q <= pcsia_pkg::BANK_RESET;
        end
        else
        begin
            latch_q <= latch_d;
            file_ptr_q <= file_ptr_d;
            bank_q <= bank_d;
        end
    end

    assign pc_next_seq = pc_q + 1'b1;

    // program flow: branch commands win over a low-byte write, which wins over a step
    always_comb
    begin
        pc_d = pc_q;
        push = 1'b0;
        pop = 1'b0;
        push_data = pc_next_seq;
        case (cmd.op)
            pcsia_pkg::PCSIA_OP_GOTO:
            begin
                pc_d = {latch_q[pcsia_pkg::LATCH_W-1:pcsia_pkg::LATCH_PAGE_LSB],
                        cmd.target};
            end
            pcsia_pkg::PCSIA_OP_CALL:
            begin
                push = 1'b1;
                push_data = pc_next_seq;
                pc_d = {latch_q[pcsia_pkg::LATCH_W-1:pcsia_pkg::LATCH_PAGE_LSB],
                        cmd.target};
            end
            pcsia_pkg::PCSIA_OP_VECTOR:
            begin
                // the interrupted instruction has not run, so its own address returns
                push = 1'b1;
                push_data = pc_q;
                pc_d = pcsia_pkg::VECTOR_ADDR;
            end
            pcsia_pkg::PCSIA_OP_RETURN,
            pcsia_pkg::PCSIA_OP_RETLIT,
            pcsia_pkg::PCSIA_OP_RETINT:
            begin
                pop = 1'b1;
                pc_d = top_data;
            end
            pcsia_pkg::PCSIA_OP_STEP:
            begin
                pc_d = pc_next_seq;
                if (wr_pc_low)
                begin
                    pc_d = {latch_q, wb_dat_w[pcsia_pkg::LOW_W-1:0]};
                end
            end
            default:
            begin
                if (wr_pc_low)
                begin
                    pc_d = {latch_q, wb_dat_w[pcsia_pkg::LOW_W-1:0]};
                end
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pc_q <= pcsia_pkg::PC_RESET;
        end
        else
        begin
            pc_q <= pc_d;
        end
    end

    assign pc = pc_q;

    // stack pointer has no bus path at all
    pcsia_stack #(
        .DEPTH(STACK_DEPTH),
        .WIDTH(pcsia_pkg::PC_W)
    ) u_stack (
        .clk(clk),
        .rst(rst),
        .push(push),
        .pop(pop),
        .push_data(push_data),
        .top_data(top_data)
    );

    pcsia_indaddr u_indaddr (
        .file_ptr(file_ptr_q),
        .ind_bank(bank_q[2]),
        .bank_hi(bank_q[1]),
        .bank_lo(bank_q[0]),
        .loc(dreq.loc),
        .eff_addr(eff_addr),
        .indirect(ind_access),
        .null_access(null_access)
    );

    // memory side is a direct path; read data is captured for the core
    assign mem_addr = eff_addr;
    assign mem_wdata = dreq.wdata;
    assign mem_we = dreq.valid && dreq.we && !null_access;

    always_comb
    begin
        drd_d = drd_q;
        if (dreq.valid && !dreq.we)
        begin
            drd_d = null_access ? pcsia_pkg::NULL_READ : mem_rdata;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            drd_q <= 8'h00;
        end
        else
        begin
            drd_q <= drd_d;
        end
    end

    assign dreq_rdata = drd_q;

endmodule : pcsia_core

/* File: testbench/pcsia_checker.sv */
`timescale 1ns/100ps
module pcsia_checker #(
    parameter int STACK_DEPTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register bus
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [7:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_dat_w,
    input wire logic [31:0] wb_dat_r,
    input wire logic wb_ack,
    // program flow
    input wire pcsia_pkg::pcsia_cmd_s cmd,
    input wire logic [12:0] pc,
    // data side
    input wire pcsia_pkg::pcsia_dreq_s dreq,
    input wire logic [7:0] dreq_rdata,
    input wire logic [8:0] mem_addr,
    input wire logic mem_we,
    input wire logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // a taken request; a low-byte write would override a step, so it is excluded
    wire logic take = wb_cyc && wb_stb && !wb_ack;
    wire logic pc_low_wr = take && wb_we && wb_sel[0] && wb_adr == pcsia_pkg::OFS_PC_LOW;
    wire logic [7:0] pc_low = pc[7:0];
    wire logic self_ind = dreq.loc == pcsia_pkg::INDIRECT_LOC && mem_addr[6:0] == 7'h00;
    wire logic rd_req = dreq.valid && !dreq.we;

    a_pc_reset: assert property (disable iff (1'b0) rst |=> pc == 13'h0000)
        else $error("pc not cleared by reset");
    a_step_inc: assert property (cmd.op == pcsia_pkg::PCSIA_OP_STEP && !pc_low_wr
        |=> pc == $past(pc) + 13'h0001) else $error("step did not advance pc");
    a_jump_low: assert property (cmd.op inside {pcsia_pkg::PCSIA_OP_GOTO,
        pcsia_pkg::PCSIA_OP_CALL} |=> pc[10:0] == $past(cmd.target))
        else $error("jump target not loaded");
    a_vector_load: assert property (cmd.op == pcsia_pkg::PCSIA_OP_VECTOR
        |=> pc == pcsia_pkg::VECTOR_ADDR) else $error("vector not loaded");
    a_call_return: assert property (cmd.op == pcsia_pkg::PCSIA_OP_CALL ##1
        cmd.op == pcsia_pkg::PCSIA_OP_RETURN |=> pc == $past(pc, 2) + 13'h0001)
        else $error("return address wrong");
    a_ack_pulse: assert property (take |=> wb_ack ##1 !wb_ack)
        else $error("ack not a single pulse");
    a_low_read: assert property (take && !wb_we && wb_adr == pcsia_pkg::OFS_PC_LOW
        |=> wb_dat_r == {24'h00_0000, $past(pc_low)}) else $error("low byte read wrong");
    a_null_read: assert property (rd_req && self_ind |=> dreq_rdata == 8'h00)
        else $error("self read not zero");
    a_null_write: assert property (dreq.valid && self_ind |-> !mem_we)
        else $error("self write not blocked");
    a_read_cap: assert property (rd_req && !self_ind |=> dreq_rdata == $past(mem_rdata))
        else $error("read data not captured");
    a_direct_loc: assert property (dreq.valid && !self_ind && dreq.loc != 7'h00
        |-> mem_addr[6:0] == dreq.loc) else $error("direct location wrong");
    a_write_pass: assert property (dreq.valid && dreq.we && !self_ind
        |-> mem_we && mem_wdata == dreq.wdata) else $error("write not passed");

    // main scenarios reached
    cover property (cmd.op == pcsia_pkg::PCSIA_OP_CALL ##1 cmd.op == pcsia_pkg::PCSIA_OP_RETURN);
    cover property (dreq.valid && self_ind);
    cover property (pc_low_wr);
endmodule : pcsia_checker

bind pcsia_core pcsia_checker #(.STACK_DEPTH(STACK_DEPTH)) u_chk (.*);

/* File: testbench/pcsia_mem_model.sv */
`timescale 1ns/100ps
module pcsia_mem_model (
    // clock
    input wire logic clk,
    // access from the block
    input wire logic [8:0] mem_addr,
    input wire logic mem_we,
    input wire logic [7:0] mem_wdata,
    output logic [7:0] mem_rdata
);
    logic [7:0] mem_q [512];
    // non-zero seed so a wrongly passed null read cannot look right
    initial
    begin
        for (int i = 0; i < 512; i++)
        begin
            mem_q[i] = 8'(i) ^ 8'h5A;
        end
    end
    // asynchronous read, valid in the address cycle
    assign mem_rdata = mem_q[mem_addr];
    // write lands on the edge
    always @(posedge clk)
    begin
        if (mem_we)
        begin
            mem_q[mem_addr] <= mem_wdata;
        end
    end
endmodule : pcsia_mem_model

/* File: testbench/test_pc_stack_indirect_addr.sv */
`timescale 1ns/100ps
module test_pc_stack_indirect_addr;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_dat_w = 32'h0000_0000;
    logic [31:0] wb_dat_r;
    logic wb_ack;
    pcsia_pkg::pcsia_cmd_s cmd = '0;
    logic [12:0] pc;
    pcsia_pkg::pcsia_dreq_s dreq = '0;
    logic [7:0] dreq_rdata;
    logic [8:0] mem_addr;
    logic mem_we;
    logic [7:0] mem_wdata;
    logic [7:0] mem_rdata;
    int err_count = 0;
    int cmp_count = 0;
    int cyc_n = 0;
    logic [31:0] rd;
    logic [7:0] dr;

    pcsia_core dut (.*);
    pcsia_mem_model u_mem (.*);

    // clock and hang guard
    initial
    begin
        forever #50 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc_n++;
        if (cyc_n > 4000)
        begin
            err_count++;
            complete_run();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    // one classic cycle; ack and read data are taken at the same rising edge
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
        @(posedge clk);
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat_w} <= {2'b11, we, adr, 4'hF, wd};
        do @(posedge clk); while (wb_ack !== 1'b1);
        rd = wb_dat_r;
        {wb_cyc, wb_stb} <= 2'b00;
    endtask : wb

    task automatic run(input pcsia_pkg::pcsia_op_e a, input logic [10:0] t,
        input pcsia_pkg::pcsia_op_e b);
        @(posedge clk);
        cmd <= '{a, t};
        if (b != pcsia_pkg::PCSIA_OP_NONE)
        begin
            @(posedge clk);
            cmd <= '{b, 11'h000};
        end
        @(posedge clk);
        cmd <= '0;
        @(negedge clk);
    endtask : run

    // data access; checks address and strobe in the request cycle
    task automatic dacc(input logic we, input logic [6:0] loc, input logic [7:0] wd,
        input logic [8:0] ea, input logic ewe);
        @(posedge clk);
        dreq <= '{1'b1, we, loc, wd};
        @(negedge clk);
        chk(mem_addr, ea);
        chk(mem_we, ewe);
        @(posedge clk);
        dreq <= '0;
        @(negedge clk);
        dr = dreq_rdata;
    endtask : dacc

    task automatic t_regs;
        chk(pc, 0);
        wb(1, 8'h10, 32'h0000_00FF);
        wb(0, 8'h10, 0);
        chk(rd, 0);
        wb(1, pcsia_pkg::OFS_PC_LATCH, 32'h0000_001A);
        wb(1, pcsia_pkg::OFS_PC_LOW, 32'h0000_005C);
        chk(pc, 13'h1A5C);
        wb(0, pcsia_pkg::OFS_PC_LOW, 0);
        chk(rd, 32'h0000_005C);
        wb(1, pcsia_pkg::OFS_PC_LATCH, 32'h0000_00FF);
        wb(0, pcsia_pkg::OFS_PC_LATCH, 0);
        chk(rd, 32'h0000_001F);
    endtask : t_regs

    task automatic t_flow;
        wb(1, pcsia_pkg::OFS_PC_LATCH, 32'h0000_0018);
        run(pcsia_pkg::PCSIA_OP_GOTO, 11'h123, pcsia_pkg::PCSIA_OP_NONE);
        chk(pc, 13'h1923);
        run(pcsia_pkg::PCSIA_OP_CALL, 11'h055, pcsia_pkg::PCSIA_OP_RETURN);
        chk(pc, 13'h1924);
        run(pcsia_pkg::PCSIA_OP_VECTOR, 11'h000, pcsia_pkg::PCSIA_OP_NONE);
        chk(pc, 13'h0004);
        run(pcsia_pkg::PCSIA_OP_RETINT, 11'h000, pcsia_pkg::PCSIA_OP_STEP);
        chk(pc, 13'h1925);
        wb(0, pcsia_pkg::OFS_PC_LATCH, 0);
        chk(rd, 32'h0000_0018);
    endtask : t_flow

    // ten calls into eight slots, then nine returns of all three kinds
    task automatic t_wrap;
        pcsia_pkg::pcsia_op_e ops[3];
        ops = '{pcsia_pkg::PCSIA_OP_RETURN, pcsia_pkg::PCSIA_OP_RETLIT,
            pcsia_pkg::PCSIA_OP_RETINT};
        wb(1, pcsia_pkg::OFS_PC_LATCH, 0);
        for (int k = 1; k <= 10; k++)
        begin
            run(pcsia_pkg::PCSIA_OP_CALL, 11'(k * 32), pcsia_pkg::PCSIA_OP_NONE);
        end
        for (int j = 1; j <= 9; j++)
        begin
            run(ops[j % 3], 11'h000, pcsia_pkg::PCSIA_OP_NONE);
            chk(pc, 13'(((j == 9) ? 9 : 10 - j) * 32 + 1));
        end
    endtask : t_wrap

    task automatic t_ind;
        wb(1, pcsia_pkg::OFS_STATUS, 0);
        wb(1, pcsia_pkg::OFS_FILE_PTR, 32'h0000_0020);
        dacc(1, 7'h20, 8'hA5, 9'h020, 1);
        dacc(0, 7'h00, 8'h00, 9'h020, 0);
        chk(dr, 8'hA5);
        wb(1, pcsia_pkg::OFS_STATUS, 32'h0000_0020);
        dacc(0, 7'h10, 8'h00, 9'h090, 0);
        chk(dr, 8'hCA);
        wb(1, pcsia_pkg::OFS_FILE_PTR, 32'h0000_0080);
        dacc(0, 7'h00, 8'h00, 9'h080, 0);
        chk(dr, 8'h00);
        dacc(1, 7'h00, 8'h33, 9'h080, 0);
        chk(u_mem.mem_q[128], 8'hDA);
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk(pc, 0);
    endtask : t_ind

    task automatic complete_run;
        if (err_count == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : complete_run

    initial
    begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        t_regs();
        t_flow();
        t_wrap();
        t_ind();
        complete_run();
    end
endmodule : test_pc_stack_indirect_addr
